// ==== include/cdp_params.svh ====
// constants of the 16-bit core datapath: widths, vectors, counts
// assumes a single 200 MHz clock and asynchronous memories on the data side
// Notes on behaviour
// [RL1] instruction address counter is 23 bits, reaching 4M instruction words
// [RL2] every instruction is one 24-bit word with a variable-length opcode field
// [RL3] next instruction is fetched one cycle ahead of execution
// [RL4] one cycle per instruction except flow changes, double-word move, table reads
// [RL5] repeat loop costs no overhead and takes interrupts at any iteration
// [RL6] sixteen 16-bit working registers, each usable as data, address or offset
// [RL7] last working register is the stack pointer for interrupts and calls
// [RL8] upper 32 KB of data space maps to program space via 8-bit page
// [RL9] mapped program space reads exactly like ordinary data space
// [RL10] one cycle holds data read, register read, data write and fetch
// [RL11] inherent, relative, literal, direct, plus seven-mode register groups
// [RL12] 17x17 multiplier: signed, unsigned, mixed; 16x16 or 8x8 operands
// [RL13] every multiply finishes in one instruction cycle
// [RL14] non-restoring divide assist stepped by repeat, 32 or 16 by 16 bits
// [RL15] divide takes 19 cycles and takes interrupts at any cycle boundary
// [RL16] vectored exceptions: eight non-maskable traps, 118 interrupt sources
// [RL17] each interrupt source takes one of seven priority levels
// [RL18] ALU works on 16-bit operands and holds the divide assist
// [RL19] wide products and quotient-remainder pairs land in adjacent registers
`ifndef CDP_PARAMS_SVH
`define CDP_PARAMS_SVH

`define CDP_PC_W      23
`define CDP_IW        24
`define CDP_NIRQ      118
`define CDP_NTRAP     8
`define CDP_RESET_VEC 23'h000000
`define CDP_TRAP_VEC  23'h000004
`define CDP_IRQ_VEC   23'h000014
`define CDP_SP_RST    16'h0800
`define CDP_SP_IDX    4'hf
`define CDP_DIV_LAST  5'd17
`define CDP_TRAP_LVL  3'h7

`endif

// ==== include/cdp_pkg.sv ====
// types shared by the core datapath and its working register file
// assumes cdp_params.svh is on the include path
package cdp_pkg;

  typedef enum logic [3:0] {
    OP_NOP  = 4'h0,
    OP_ADD  = 4'h1,
    OP_SUB  = 4'h2,
    OP_AND  = 4'h3,
    OP_IOR  = 4'h4,
    OP_XOR  = 4'h5,
    OP_MOVL = 4'h6,
    OP_MOVF = 4'h7,
    OP_STOR = 4'h8,
    OP_MUL  = 4'h9,
    OP_DIV  = 4'ha,
    OP_BRA  = 4'hb,
    OP_CALL = 4'hc,
    OP_RET  = 4'hd,
    OP_RPT  = 4'he,
    OP_MISC = 4'hf
  } cdp_op_type;

  typedef enum logic [2:0] {
    S_RUN     = 3'b000,
    S_SECOND  = 3'b001,
    S_PUSH_HI = 3'b010,
    S_PUSH_RC = 3'b011,
    S_POP_HI  = 3'b100,
    S_POP_LO  = 3'b101
  } cdp_state_type;

  typedef struct packed {
    logic        en;
    logic [3:0]  addr;
    logic [15:0] data;
  } cdp_wr_type;

  typedef struct packed {
    logic [15:0][15:0] mem;
    logic [15:0]       a;
    logic [15:0]       b;
    logic [15:0]       c;
  } cdp_rf_type;

  typedef struct packed {
    cdp_state_type st;
    logic [22:0]   pm_addr;
    logic [23:0]   ir;
    logic          ir_ok;
    logic [22:0]   exec_pc;
    logic [22:0]   tgt;
    logic [22:0]   sav;
    logic          frame3;
    logic [2:0]    plvl;
    logic [13:0]   rcount;
    logic          rpt;
    logic [2:0]    ipl;
    logic [7:0]    page;
    logic          psv_en;
    logic [17:0]   div_r;
    logic [15:0]   div_q;
    logic [15:0]   div_d;
    logic          neg_q;
    logic          neg_r;
    logic [15:0]   dm_waddr;
    logic [15:0]   dm_wdata;
    logic          dm_we;
    logic          irq_ack;
    logic          trap_ack;
    logic [6:0]    ack_id;
  } cdp_core_type;

endpackage

// ==== verilog/cdp_regfile.sv ====
// sixteen working registers, two write ports, three registered read ports
// assumes the core presents read addresses one cycle before it uses the data
`timescale 1ns/1ps
`include "cdp_params.svh"
module cdp_regfile (
  input  wire logic               clk,   // core clock
  input  wire logic               rst_n, // async reset, active low
  input  wire logic [3:0]         ra,    // read address, ports a and c
  input  wire logic [3:0]         rb,    // read address, port b
  input  wire cdp_pkg::cdp_wr_type w1,   // primary write
  input  wire cdp_pkg::cdp_wr_type w2,   // pair or pointer write
  output logic      [15:0]        a,     // register ra
  output logic      [15:0]        b,     // register rb
  output logic      [15:0]        c,     // odd partner of ra
  output logic      [15:0]        sp     // stack register
);
  import cdp_pkg::*;

  cdp_rf_type r_q;
  cdp_rf_type r_d;

  // [RL6] uniform register array
  // reads see this cycle's writes, so back-to-back use needs no stall
  always_comb begin
    r_d = r_q;
    if (w1.en) begin
      r_d.mem[w1.addr] = w1.data;
    end
    if (w2.en) begin
      r_d.mem[w2.addr] = w2.data;
    end
    r_d.a = r_d.mem[ra];
    r_d.b = r_d.mem[rb];
    r_d.c = r_d.mem[{ra[3:1], 1'b1}];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_q                    <= '0;
      r_q.mem[`CDP_SP_IDX]   <= `CDP_SP_RST;
    end else begin
      r_q <= r_d;
    end
  end

  assign a  = r_q.a;
  assign b  = r_q.b;
  assign c  = r_q.c;
  // [RL7] last register is the stack
  assign sp = r_q.mem[`CDP_SP_IDX];
endmodule

// ==== verilog/cdp_core.sv ====
// 16-bit core: prefetch, execute, multiply, divide assist, stack, exceptions
// assumes program memory answers PM_ADDR in the same cycle, data memory likewise
`timescale 1ns/1ps
`include "cdp_params.svh"
module cdp_core (
  input  wire logic [0:0]              REF_CLK,   // 200 MHz clock
  input  wire logic                    RSTN,      // async reset, active low
  output logic      [`CDP_PC_W-1:0]    PM_ADDR,   // fetch address
  input  wire logic [`CDP_IW-1:0]      PM_RDATA,  // fetched word
  output logic      [15:0]             DM_RADDR,  // data read address
  input  wire logic [15:0]             DM_RDATA,  // data read word
  output logic      [15:0]             DM_WADDR,  // data write address
  output logic      [15:0]             DM_WDATA,  // data write word
  output logic                         DM_WE,     // data write strobe
  output logic      [`CDP_PC_W-1:0]    PS_ADDR,   // program-space data address
  input  wire logic [`CDP_IW-1:0]      PS_RDATA,  // program-space data word
  input  wire logic [`CDP_NTRAP-1:0]   TRAP_REQ,  // trap requests
  input  wire logic [`CDP_NIRQ-1:0]    IRQ_REQ,   // interrupt requests
  input  wire logic [3*`CDP_NIRQ-1:0]  IRQ_LEVEL, // 3-bit level per source
  output logic                         IRQ_ACK,   // interrupt taken
  output logic                         TRAP_ACK,  // trap taken
  output logic      [6:0]              ACK_ID,    // taken source number
  output logic      [2:0]              CPU_LEVEL  // running level
);
  import cdp_pkg::*;

  cdp_core_type c, n;
  cdp_wr_type   w1, w2;
  logic [15:0]  ra_v, rb_v, rc_v, sp_v;
  logic [3:0]   ra_s, rb_s;
  logic         adv, redir, take, trap_any, div_fin, mapped;
  logic [2:0]   best_l;
  logic [6:0]   best_i;
  logic [2:0]   trap_i;
  logic [15:0]  ea, rd_addr, rdat, src, res;
  logic [16:0]  xa, xb;
  logic [33:0]  prod;
  logic [22:0]  tgt;
  logic [4:0]   idx;
  cdp_op_type   op;

  cdp_regfile cdp_regfile_inst (
    .clk   (REF_CLK),
    .rst_n (RSTN),
    .ra    (ra_s),
    .rb    (rb_s),
    .w1    (w1),
    .w2    (w2),
    .a     (ra_v),
    .b     (rb_v),
    .c     (rc_v),
    .sp    (sp_v)
  );

  // [RL16] [RL17] trap and level arbitration
  always_comb begin
    best_l = 3'h0;
    best_i = 7'h0;
    trap_i = 3'h0;
    for (int i = `CDP_NIRQ - 1; i >= 0; i--) begin
      if (IRQ_REQ[i] && IRQ_LEVEL[3*i +: 3] >= best_l && IRQ_LEVEL[3*i +: 3] != 3'h0) begin
        best_l = IRQ_LEVEL[3*i +: 3];
        best_i = 7'(i);
      end
    end
    for (int i = `CDP_NTRAP - 1; i >= 0; i--) begin
      if (TRAP_REQ[i]) begin
        trap_i = 3'(i);
      end
    end
  end

  assign trap_any = |TRAP_REQ;

  always_comb begin
    logic [17:0] sh;
    logic [17:0] rn;
    logic [31:0] dvd;
    logic [31:0] dmag;
    logic [15:0] smag;
    logic        dneg;
    logic        sneg;
    logic        sa;
    logic        sb;
    sh = '0; rn = '0; dvd = '0; dmag = '0; smag = '0;
    dneg = 1'b0; sneg = 1'b0; sa = 1'b0; sb = 1'b0;
    n = c;
    n.dm_we = 1'b0;
    n.irq_ack = 1'b0;
    n.trap_ack = 1'b0;
    w1 = '0;
    w2 = '0;
    adv = 1'b0;
    redir = 1'b0;
    tgt = c.tgt;
    div_fin = 1'b0;
    op = cdp_op_type'(c.ir[23:20]);
    // [RL11] register group modes on the source pointer
    unique case (c.ir[14:12])
      3'h4:    ea = 16'(ra_v + 16'h0002);
      3'h5:    ea = 16'(ra_v - 16'h0002);
      3'h6:    ea = 16'(ra_v + rb_v);
      default: ea = ra_v;
    endcase
    if (c.st == S_POP_HI || c.st == S_POP_LO || (c.st == S_RUN && op == OP_RET)) begin
      rd_addr = 16'(sp_v - 16'h0002);
    end else if (op == OP_MOVF) begin
      rd_addr = {c.ir[19:5], 1'b0};
    end else if (c.st == S_SECOND) begin
      rd_addr = 16'(ea + 16'h0002);
    end else begin
      rd_addr = ea;
    end
    // [RL8] [RL9] upper half of data space reads program space when enabled
    mapped = c.psv_en && rd_addr[15] && !(op == OP_MISC && c.ir[19:16] == 4'h1);
    // pending write not yet in memory: forward it
    if (mapped) begin
      rdat = PS_RDATA[15:0];
    end else if (c.dm_we && c.dm_waddr == rd_addr) begin
      rdat = c.dm_wdata;
    end else begin
      rdat = DM_RDATA;
    end
    src = (c.ir[14:12] == 3'h0 || c.ir[14:12] == 3'h7) ? ra_v : rdat;
    // [RL18] 16-bit ALU
    unique case (op)
      OP_SUB:  res = 16'(rb_v - src);
      OP_AND:  res = rb_v & src;
      OP_IOR:  res = rb_v | src;
      OP_XOR:  res = rb_v ^ src;
      default: res = 16'(rb_v + src);
    endcase
    // [RL12] operands widened to 17 bits per sign mode
    sa = c.ir[13:12] == 2'b01 || c.ir[13:12] == 2'b10;
    sb = c.ir[13:12] == 2'b01 || c.ir[13:12] == 2'b11;
    xa = c.ir[14] ? {{9{sa & ra_v[7]}}, ra_v[7:0]} : {sa & ra_v[15], ra_v};
    xb = c.ir[14] ? {{9{sb & rb_v[7]}}, rb_v[7:0]} : {sb & rb_v[15], rb_v};
    prod = $signed(xa) * $signed(xb);
    idx = c.rpt ? 5'(`CDP_DIV_LAST - c.rcount[4:0]) : `CDP_DIV_LAST;
    take = c.st == S_RUN && c.ir_ok && (trap_any || best_l > c.ipl);

    unique case (c.st)
      S_RUN, S_SECOND: begin
        if (!c.ir_ok) begin
          adv = 1'b1;
        end else if (take) begin
          // [RL5] [RL15] taken between iterations, resume at this word
          n.dm_we = 1'b1;
          n.dm_waddr = sp_v;
          n.dm_wdata = c.exec_pc[15:0];
          w2 = '{en: 1'b1, addr: `CDP_SP_IDX, data: 16'(sp_v + 16'h0002)};
          n.sav = c.exec_pc;
          n.frame3 = 1'b1;
          n.trap_ack = trap_any;
          n.irq_ack = !trap_any;
          n.ack_id = trap_any ? {4'h0, trap_i} : best_i;
          n.plvl = trap_any ? `CDP_TRAP_LVL : best_l;
          // [RL16] vectored entry
          n.tgt = trap_any ? 23'(`CDP_TRAP_VEC + {19'h0, trap_i, 1'b0})
                           : 23'(`CDP_IRQ_VEC + {15'h0, best_i, 1'b0});
          n.st = S_PUSH_HI;
        end else begin
          adv = 1'b1;
          unique case (op)
            OP_ADD, OP_SUB, OP_AND, OP_IOR, OP_XOR, OP_STOR: begin
              // [RL10] read, register read, write and fetch in one cycle
              if (op == OP_STOR) begin
                n.dm_we = !(c.psv_en && ea[15]);
                n.dm_waddr = ea;
                n.dm_wdata = rb_v;
              end else begin
                w1 = '{en: 1'b1, addr: c.ir[3:0], data: res};
              end
              if (c.ir[14:12] >= 3'h2 && c.ir[14:12] <= 3'h5) begin
                w2 = '{en: 1'b1, addr: c.ir[7:4],
                       data: c.ir[12] ? 16'(ra_v - 16'h0002) : 16'(ra_v + 16'h0002)};
              end
            end
            OP_MOVL: w1 = '{en: 1'b1, addr: c.ir[3:0], data: c.ir[19:4]};
            OP_MOVF: w1 = '{en: 1'b1, addr: c.ir[3:0], data: rdat};
            OP_MUL: begin
              // [RL13] [RL19] product in one cycle, written as a pair
              w1 = '{en: 1'b1, addr: c.ir[3:0], data: prod[15:0]};
              w2 = '{en: 1'b1, addr: {c.ir[3:1], 1'b1}, data: prod[31:16]};
            end
            OP_DIV: begin
              // [RL14] non-restoring step on magnitudes, signs fixed at the end
              if (idx == 5'd0) begin
                dvd = c.ir[13] ? {rc_v, ra_v}
                               : {{16{c.ir[12] & ra_v[15]}}, ra_v};
                dneg = c.ir[12] & dvd[31];
                sneg = c.ir[12] & rb_v[15];
                dmag = dneg ? 32'(32'h0 - dvd) : dvd;
                smag = sneg ? 16'(16'h0 - rb_v) : rb_v;
                n.div_r = {2'b00, dmag[31:16]};
                n.div_q = dmag[15:0];
                n.div_d = smag;
                n.neg_q = dneg ^ sneg;
                n.neg_r = dneg;
              end else if (idx < `CDP_DIV_LAST) begin
                sh = {c.div_r[16:0], c.div_q[15]};
                rn = c.div_r[17] ? 18'(sh + {2'b00, c.div_d}) : 18'(sh - {2'b00, c.div_d});
                n.div_r = rn;
                n.div_q = {c.div_q[14:0], ~rn[17]};
              end else begin
                // [RL19] quotient low, remainder in the odd partner
                div_fin = 1'b1;
                rn = c.div_r[17] ? 18'(c.div_r + {2'b00, c.div_d}) : c.div_r;
                w1 = '{en: 1'b1, addr: c.ir[3:0],
                       data: c.neg_q ? 16'(16'h0 - c.div_q) : c.div_q};
                w2 = '{en: 1'b1, addr: {c.ir[3:1], 1'b1},
                       data: c.neg_r ? 16'(16'h0 - rn[15:0]) : rn[15:0]};
              end
            end
            OP_BRA: begin
              // [RL11] [RL4] relative flow change costs a bubble
              tgt = 23'(c.exec_pc + 23'h000002 + {{6{c.ir[15]}}, c.ir[15:0], 1'b0});
              redir = 1'b1;
            end
            OP_CALL: begin
              // [RL7] return address pushed through the stack register
              n.sav = 23'(c.exec_pc + 23'h000002);
              n.dm_we = 1'b1;
              n.dm_waddr = sp_v;
              n.dm_wdata = n.sav[15:0];
              w2 = '{en: 1'b1, addr: `CDP_SP_IDX, data: 16'(sp_v + 16'h0002)};
              n.tgt = {2'b00, c.ir[19:0], 1'b0};
              n.frame3 = 1'b0;
              n.st = S_PUSH_HI;
              adv = 1'b0;
            end
            OP_RET: begin
              w2 = '{en: 1'b1, addr: `CDP_SP_IDX, data: 16'(sp_v - 16'h0002)};
              if (c.ir[0]) begin
                n.rcount = rdat[13:0];
                n.st = S_POP_HI;
              end else begin
                n.tgt[22:16] = rdat[6:0];
                n.st = S_POP_LO;
              end
              adv = 1'b0;
            end
            OP_RPT: begin
              n.rcount = c.ir[13:0];
              n.rpt = 1'b1;
            end
            OP_MISC: begin
              unique case (c.ir[19:16])
                4'h0: begin
                  // [RL4] double-word move, second half next cycle
                  w1 = '{en: 1'b1, addr: c.st == S_SECOND ? {c.ir[3:1], 1'b1} : c.ir[3:0],
                         data: rdat};
                  adv = c.st == S_SECOND;
                  n.st = c.st == S_SECOND ? S_RUN : S_SECOND;
                end
                4'h1: begin
                  // [RL4] table read: low word, then upper byte
                  w1 = '{en: 1'b1, addr: c.st == S_SECOND ? {c.ir[3:1], 1'b1} : c.ir[3:0],
                         data: c.st == S_SECOND ? {8'h00, PS_RDATA[23:16]} : PS_RDATA[15:0]};
                  adv = c.st == S_SECOND;
                  n.st = c.st == S_SECOND ? S_RUN : S_SECOND;
                end
                4'h2: begin
                  n.page = c.ir[7:0];
                  n.psv_en = c.ir[8];
                end
                4'h3: n.ipl = c.ir[2:0];
                default: ;
              endcase
            end
            default: ;
          endcase
          // [RL5] repeated word stays in place until the count runs out
          if (c.rpt && op != OP_RPT && adv) begin
            if (c.rcount == 14'h0) begin
              n.rpt = 1'b0;
            end else begin
              n.rcount = 14'(c.rcount - 14'h1);
              adv = 1'b0;
            end
          end
        end
      end
      S_PUSH_HI: begin
        n.dm_we = 1'b1;
        n.dm_waddr = sp_v;
        n.dm_wdata = {c.rpt, c.ipl, 5'h00, c.sav[22:16]};
        w2 = '{en: 1'b1, addr: `CDP_SP_IDX, data: 16'(sp_v + 16'h0002)};
        n.st = c.frame3 ? S_PUSH_RC : S_RUN;
        redir = !c.frame3;
      end
      S_PUSH_RC: begin
        n.dm_we = 1'b1;
        n.dm_waddr = sp_v;
        n.dm_wdata = {2'b00, c.rcount};
        w2 = '{en: 1'b1, addr: `CDP_SP_IDX, data: 16'(sp_v + 16'h0002)};
        n.ipl = c.plvl;
        n.rpt = 1'b0;
        n.st = S_RUN;
        redir = 1'b1;
      end
      S_POP_HI: begin
        w2 = '{en: 1'b1, addr: `CDP_SP_IDX, data: 16'(sp_v - 16'h0002)};
        n.rpt = rdat[15];
        n.ipl = rdat[14:12];
        n.tgt[22:16] = rdat[6:0];
        n.st = S_POP_LO;
      end
      S_POP_LO: begin
        w2 = '{en: 1'b1, addr: `CDP_SP_IDX, data: 16'(sp_v - 16'h0002)};
        tgt = {c.tgt[22:16], rdat};
        redir = 1'b1;
        n.st = S_RUN;
      end
      default: n.st = S_RUN;
    endcase

    // [RL1] [RL3] fetch runs one word ahead of execute
    if (redir) begin
      n.pm_addr = tgt;
      n.ir_ok = 1'b0;
    end else if (adv) begin
      // [RL2] whole 24-bit word captured
      n.ir = PM_RDATA;
      n.ir_ok = 1'b1;
      n.exec_pc = c.pm_addr;
      n.pm_addr = 23'(c.pm_addr + 23'h000002);
    end
    ra_s = adv ? PM_RDATA[7:4] : c.ir[7:4];
    rb_s = adv ? PM_RDATA[11:8] : c.ir[11:8];
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      c         <= '0;
      c.st      <= S_RUN;
      c.pm_addr <= `CDP_RESET_VEC;
    end else begin
      c <= n;
    end
  end

  assign PM_ADDR   = c.pm_addr;
  assign DM_RADDR  = rd_addr;
  assign PS_ADDR   = (op == OP_MISC && c.ir[19:16] == 4'h1) ? {c.page[6:0], ra_v}
                                                             : {c.page, rd_addr[14:1], 1'b0};
  assign DM_WADDR  = c.dm_waddr;
  assign DM_WDATA  = c.dm_wdata;
  assign DM_WE     = c.dm_we;
  assign IRQ_ACK   = c.irq_ack;
  assign TRAP_ACK  = c.trap_ack;
  assign ACK_ID    = c.ack_id;
  assign CPU_LEVEL = c.ipl;

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);

  sequence s_push3;
    c.dm_we [*3];
  endsequence
  sequence s_bubble;
    !c.ir_ok ##1 c.ir_ok;
  endsequence

  chk_fetch_ahead: assert property ( // [RL1] [RL2] [RL3]
    adv && !redir |=> c.ir == $past(PM_RDATA) && c.pm_addr == 23'($past(c.pm_addr) + 23'h2))
    else $error("fetch did not advance one word");
  chk_single_cycle: assert property ( // [RL4] [RL10]
    c.st == S_RUN && c.ir_ok && !take && !c.rpt && op inside {OP_ADD, OP_SUB, OP_STOR}
    |=> c.exec_pc == 23'($past(c.exec_pc) + 23'h2))
    else $error("plain instruction took more than one cycle");
  chk_branch_gap: assert property ( // [RL4]
    c.st == S_RUN && c.ir_ok && !take && op == OP_BRA |=> s_bubble)
    else $error("branch bubble missing");
  chk_repeat_hold: assert property ( // [RL5]
    c.st == S_RUN && c.ir_ok && !take && c.rpt && op != OP_RPT && c.rcount != 14'h0
    |=> $stable(c.ir) && c.rcount == 14'($past(c.rcount) - 14'h1))
    else $error("repeat did not hold the word");
  chk_entry_push: assert property ( // [RL7] [RL16]
    take |=> c.dm_waddr == $past(sp_v) && (c.irq_ack || c.trap_ack) ##0 s_push3
    ##0 (c.st == S_RUN && !c.ir_ok))
    else $error("exception entry frame wrong");
  chk_level_raise: assert property ( // [RL17]
    take && !trap_any |-> ##3 c.ipl == $past(best_l, 3) && c.ipl > $past(c.ipl, 3))
    else $error("level not raised on entry");
  chk_page_map: assert property ( // [RL8] [RL9]
    c.st == S_RUN && c.ir_ok && !take && op == OP_MOVF && mapped
    |-> w1.data == PS_RDATA[15:0] && PS_ADDR[22:15] == c.page)
    else $error("mapped read not from program space");
  chk_mul_pair: assert property ( // [RL12] [RL13] [RL19]
    c.st == S_RUN && c.ir_ok && !take && op == OP_MUL && c.ir[14:12] == 3'h0
    |-> {w2.data, w1.data} == ra_v * rb_v && w2.addr == {c.ir[3:1], 1'b1})
    else $error("unsigned product wrong");
  chk_div_final: assert property ( // [RL14] [RL15] [RL19]
    div_fin |-> w1.en && w2.en && w2.addr == {w1.addr[3:1], 1'b1} ##1 !c.rpt)
    else $error("divide result not written as a pair");
endmodule

// ==== dv/cdp_mem_model.sv ====
// program, data and program-space memories facing the core
// assumes the core reads combinationally and writes at its strobe's edge
`timescale 1ns/1ps
module cdp_mem_model (
  input  wire logic        clk,      // core clock
  input  wire logic [22:0] pm_addr,  // fetch address
  output logic      [23:0] pm_rdata, // fetched word
  input  wire logic [15:0] dm_raddr, // data read address
  output logic      [15:0] dm_rdata, // data read word
  input  wire logic [15:0] dm_waddr, // data write address
  input  wire logic [15:0] dm_wdata, // data write word
  input  wire logic        dm_we,    // data write strobe
  input  wire logic [22:0] ps_addr,  // program-space data address
  output logic      [23:0] ps_rdata  // program-space data word
);
  logic [23:0] pm [0:255];
  logic [15:0] dm [0:2047];
  // async answers, same cycle as the address
  assign pm_rdata = pm[pm_addr[8:1]];
  assign dm_rdata = dm[dm_raddr[11:1]];
  // pattern tied to the address so a stale word cannot pass
  assign ps_rdata = {ps_addr, 1'b1};
  always @(posedge clk) begin
    if (dm_we === 1'b1) begin
      dm[dm_waddr[11:1]] <= dm_wdata;
    end
  end
endmodule

// ==== dv/tb_cpu_core_datapath.sv ====
// self-checking bench for the core: arithmetic, stores, entry of interrupts and traps
// assumes cdp_core and the memory model; memory image loaded before reset release
`timescale 1ns/1ps
module tb_cpu_core_datapath;
  logic          ref_clk = 1'b0;
  logic          rstn = 1'b0;
  logic [22:0]   pm_addr, ps_addr;
  logic [23:0]   pm_rdata, ps_rdata;
  logic [15:0]   dm_raddr, dm_rdata, dm_waddr, dm_wdata;
  logic          dm_we, irq_ack, trap_ack;
  logic [7:0]    trap_req = '0;
  logic [117:0]  irq_req = '0;
  logic [353:0]  irq_level = '0;
  logic [6:0]    ack_id;
  logic [2:0]    cpu_level;
  logic [15:0]   wa[$], wd[$];
  int            wt[$];
  int            n_mismatch = 0;
  int            n_compared = 0;
  int            cyc = 0;

  cdp_core cdp_core_inst (.REF_CLK(ref_clk), .RSTN(rstn), .PM_ADDR(pm_addr),
    .PM_RDATA(pm_rdata), .DM_RADDR(dm_raddr), .DM_RDATA(dm_rdata), .DM_WADDR(dm_waddr),
    .DM_WDATA(dm_wdata), .DM_WE(dm_we), .PS_ADDR(ps_addr), .PS_RDATA(ps_rdata),
    .TRAP_REQ(trap_req), .IRQ_REQ(irq_req), .IRQ_LEVEL(irq_level), .IRQ_ACK(irq_ack),
    .TRAP_ACK(trap_ack), .ACK_ID(ack_id), .CPU_LEVEL(cpu_level));
  cdp_mem_model cdp_mem_model_inst (.clk(ref_clk), .pm_addr(pm_addr), .pm_rdata(pm_rdata),
    .dm_raddr(dm_raddr), .dm_rdata(dm_rdata), .dm_waddr(dm_waddr), .dm_wdata(dm_wdata),
    .dm_we(dm_we), .ps_addr(ps_addr), .ps_rdata(ps_rdata));

  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (dm_we === 1'b1) begin
      wa.push_back(dm_waddr);
      wd.push_back(dm_wdata);
      wt.push_back(cyc);
    end
  end

  function automatic logic [23:0] ins(input logic [3:0] op, input logic [2:0] md,
                                      input logic [3:0] wb, ws, wdst);
    return {op, 5'h00, md, wb, ws, wdst};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic wait_writes(input int n);
    for (int i = 0; i < 300 && wa.size() < n; i++) @(posedge ref_clk);
    if (wa.size() < n) begin
      n_mismatch++;
      test_done();
    end
  endtask
  task automatic wait_ack(input logic trap);
    for (int i = 0; i < 60 && (trap ? trap_ack : irq_ack) !== 1'b1; i++) @(posedge ref_clk);
    check(trap ? trap_ack : irq_ack, 1);
  endtask
  task automatic wait_pc(input logic [22:0] tgt);
    for (int i = 0; i < 20 && pm_addr !== tgt; i++) @(posedge ref_clk);
    check(pm_addr, tgt);
  endtask

  // back-to-back add, multiplies and stores, one instruction per cycle
  task automatic scn_alu;
    logic [15:0] exp_d [5] = '{16'h7fff, 16'hfffe, 16'h7fff, 16'hfffe, 16'h0000};
    wait_writes(5);
    for (int k = 0; k < 5; k++) begin
      check(wd[k], exp_d[k]);
      check(wa[k], 16'h0100 + 2 * k);
      if (k > 0) check(wt[k] - wt[k - 1], 1);
    end
  endtask
  // 65534 / 32769 under repeat, then a read through page 05 at 0x8010
  task automatic scn_div;
    wait_writes(8);
    check(wd[5], 16'h0001);
    check(wd[6], 16'h7ffd);
    check(wa[6], 16'h0102);
    // repeat word, 18 divide words, then the store cycle
    check(wt[5] - wt[4], 20);
    // model answers {address, 1}: address 0x28010
    check(wd[7], 16'h0021);
  endtask
  // level 0 stays silent, then the higher of two levels wins
  task automatic scn_irq;
    int acks = 0;
    irq_req[7] <= 1'b1;
    repeat (30) begin
      @(posedge ref_clk);
      acks += (irq_ack === 1'b1);
    end
    check(acks, 0);
    wa.delete();
    wd.delete();
    irq_req[7] <= 1'b0;
    irq_level[17:15] <= 3'd3;
    irq_level[29:27] <= 3'd6;
    irq_req[5] <= 1'b1;
    irq_req[9] <= 1'b1;
    wait_ack(1'b0);
    check(ack_id, 9);
    irq_req <= '0;
    wait_writes(3);
    for (int k = 0; k < 3; k++) check(wa[k], 16'h0800 + 2 * k);
    // resume address is the spinning word
    check(wd[0], 16'h012c);
    @(posedge ref_clk);
    check(cpu_level, 6);
    wait_pc(23'h000026);
  endtask
  // a trap preempts the running handler and stacks above its frame
  task automatic scn_trap;
    wa.delete();
    wd.delete();
    trap_req[2] <= 1'b1;
    wait_ack(1'b1);
    check(ack_id, 2);
    trap_req <= '0;
    wait_writes(3);
    for (int k = 0; k < 3; k++) check(wa[k], 16'h0806 + 2 * k);
    check(wd[0], 16'h0026);
    // saved level 6 sits in bits 14:12 of the second word
    check(wd[1], 16'h6000);
    @(posedge ref_clk);
    check(cpu_level, 7);
    wait_pc(23'h000008);
  endtask

  initial begin
    // every word a branch to itself, so vectors and the tail just spin
    for (int i = 0; i < 256; i++) cdp_mem_model_inst.pm[i] = 24'hb0ffff;
    for (int i = 0; i < 2048; i++) cdp_mem_model_inst.dm[i] = 16'h0000;
    cdp_mem_model_inst.pm[0] = 24'hb0007f;
    cdp_mem_model_inst.pm[128] = {4'h6, 16'h8001, 4'h1};
    cdp_mem_model_inst.pm[129] = {4'h6, 16'hfffe, 4'h2};
    for (int j = 0; j < 5; j++)
      cdp_mem_model_inst.pm[130 + j] = {4'h6, 16'h0100 + 16'(2 * j), 4'(10 + j)};
    cdp_mem_model_inst.pm[135] = ins(4'h1, 3'd0, 4'h1, 4'h2, 4'h4);
    cdp_mem_model_inst.pm[136] = ins(4'h9, 3'd0, 4'h1, 4'h2, 4'h6);
    cdp_mem_model_inst.pm[137] = ins(4'h9, 3'd1, 4'h1, 4'h2, 4'h8);
    cdp_mem_model_inst.pm[138] = ins(4'h8, 3'd1, 4'h4, 4'ha, 4'h0);
    for (int j = 0; j < 4; j++)
      cdp_mem_model_inst.pm[139 + j] = ins(4'h8, 3'd1, 4'(6 + j), 4'(11 + j), 4'h0);
    // repeat 17, divide W6 by W1 into W2/W3, store both, page 05 on, mapped read
    cdp_mem_model_inst.pm[143] = 24'he00011;
    cdp_mem_model_inst.pm[144] = ins(4'ha, 3'd0, 4'h1, 4'h6, 4'h2);
    cdp_mem_model_inst.pm[145] = ins(4'h8, 3'd1, 4'h2, 4'ha, 4'h0);
    cdp_mem_model_inst.pm[146] = ins(4'h8, 3'd1, 4'h3, 4'hb, 4'h0);
    cdp_mem_model_inst.pm[147] = 24'hf20105;
    cdp_mem_model_inst.pm[148] = 24'h780105;
    cdp_mem_model_inst.pm[149] = ins(4'h8, 3'd1, 4'h5, 4'hc, 4'h0);
    repeat (6) @(posedge ref_clk);
    rstn <= 1'b1;
    scn_alu();
    scn_div();
    scn_irq();
    scn_trap();
    test_done();
  end
endmodule
